// File: core/bba_pkg.sv
// Constants for the bridge bus arbitration block.
// Assumes byte-wide configuration access at the listed byte offsets.
package bba_pkg;
   // Configuration byte offsets
   localparam logic [7:0] CMD_LO_OFS   = 8'h04;
   localparam logic [7:0] CMD_HI_OFS   = 8'h05;
   localparam logic [7:0] PSTAT_HI_OFS = 8'h07;
   localparam logic [7:0] SSTAT_HI_OFS = 8'h1f;
   localparam logic [7:0] SERR_CTL_OFS = 8'h60;
   localparam logic [7:0] SERR_STS_OFS = 8'h61;
   localparam logic [7:0] ARB_DIS_OFS  = 8'h6c;
   localparam logic [7:0] TIER_OFS     = 8'h6d;
   // Field positions
   localparam int CMD_SERR_EN_BIT = 8;
   localparam int ARB_DIS_BIT     = 6;
   localparam int SERR_ARB_TO_BIT = 0;
   localparam int STAT_SERR_BIT   = 14;
   localparam int STAT_HI_BIT     = STAT_SERR_BIT - 8;
   // Reset values
   localparam logic [15:0] CMD_RST      = 16'h0000;
   localparam logic [7:0]  SERR_CTL_RST = 8'h00;
   localparam logic [7:0]  ARB_DIS_RST  = 8'h00;
   localparam logic [6:0]  TIER_RST     = 7'h00;
   // Masters and timing, in bus clock cycles
   localparam int NUM_MASTERS        = 7;
   localparam int BRIDGE_IDX         = 6;
   localparam int LO_GROUP_SLOT      = 7;
   localparam int ARB_TIMEOUT_CYCLES = 16;
   localparam int BACKOFF_CYCLES     = 2;

   typedef enum logic [4:0] {
      P_IDLE  = 5'h01,
      P_REQ   = 5'h02,
      P_START = 5'h04,
      P_BUSY  = 5'h08,
      P_BACK  = 5'h10
   } bba_pri_e;

   typedef enum logic [2:0] {
      SA_IDLE  = 3'h1,
      SA_GRANT = 3'h2,
      SA_OWN   = 3'h4
   } bba_sec_e;
endpackage : bba_pkg

// File: core/bba_rr_pick.sv
// Round-robin picker: first requester after the last winner.
// Assumes N is at most 8; purely combinational.
`timescale 1ns/100ps
module bba_rr_pick #(
   parameter int N = 7
) (
   input  wire logic [N-1:0] req,
   input  wire logic [2:0]   last,
   output logic [2:0]        win,
   output logic              any
);
   int j;

   always_comb begin
      j   = 0;
      win = last;
      any = 1'b0;
      for (int k = 1; k <= N; k++) begin
         j = (int'(last) + k) % N;
         if (!any && req[j]) begin
            any = 1'b1;
            win = 3'(j);
         end
      end
   end
endmodule : bba_rr_pick

// File: core/bba_grant_timer.sv
// Counts cycles a grant stands unused; pulses once the limit passes.
// Assumes run falls as soon as the granted master starts or loses grant.
`timescale 1ns/100ps
module bba_grant_timer
   import bba_pkg::*;
(
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic run,
   output logic      expired
);
   localparam logic [4:0] LAST = 5'(ARB_TIMEOUT_CYCLES - 1);
   logic [4:0] count_ff;
   logic [4:0] nxt_count;
   logic       expired_ff;
   logic       nxt_expired;

   always_comb begin
      nxt_count   = run ? ((count_ff == LAST) ? count_ff : count_ff + 5'h1)
                        : 5'h0;
      nxt_expired = run && (count_ff == LAST);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_ff   <= 5'h0;
         expired_ff <= 1'b0;
      end else begin
         count_ff   <= nxt_count;
         expired_ff <= nxt_expired;
      end
   end

   assign expired = expired_ff;
endmodule : bba_grant_timer

// File: core/bba_arbiter.sv
// Bridge bus arbitration: primary request/park, secondary arbiter, SERR.
// Assumes one bus clock, byte-wide config port, datapath after start.
`timescale 1ns/100ps
module bba_arbiter
   import bba_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_wdata,
   output logic [7:0]       cfg_rdata,
   input  wire logic        fwd_pending,
   input  wire logic        pri_txn_done,
   input  wire logic        pri_txn_retry,
   input  wire logic        pri_grant_n,
   output logic             pri_req_n,
   output logic             pri_start,
   output logic             upstream_cycle_frame_n,
   output logic             upstream_cycle_frame_oe,
   output logic [31:0]      upstream_addr_data_bus,
   output logic             upstream_addr_data_bus_oe,
   output logic [3:0]       upstream_cmd_byte_enables,
   output logic             upstream_cmd_byte_enables_oe,
   output logic             upstream_parity,
   output logic             upstream_parity_oe,
   output logic             pri_syserr_n,
   output logic             pri_syserr_oe,
   input  wire logic        outside_arbiter_select,
   input  wire logic        downstream_request_zero_n,
   input  wire logic [4:0]  downstream_requests_one_to_five_n,
   output logic             downstream_grant_zero_n,
   output logic [4:0]       downstream_grants_one_to_five_n,
   output logic [4:0]       downstream_grants_one_to_five_oe,
   input  wire logic        bridge_sec_req,
   output logic             bridge_sec_gnt,
   input  wire logic        sec_frame_n,
   input  wire logic        sec_bus_idle,
   input  wire logic        sec_syserr_n
);
   function automatic logic [6:0] onehot7(input logic [2:0] idx);
      onehot7 = 7'h01 << idx;
   endfunction : onehot7

   // Configuration state
   logic [15:0] cmd_ff, nxt_cmd;
   logic [7:0]  serr_ctl_ff, nxt_serr_ctl, arb_dis_ff, nxt_arb_dis, rdata_ff;
   logic [7:0]  nxt_rdata;
   logic [6:0]  tier_ff, nxt_tier;
   logic        serr_flag_ff, nxt_serr_flag, pstat_ff, nxt_pstat;
   logic        sstat_ff, nxt_sstat, serr_oe_ff, nxt_serr_oe, low_lvl_ff;
   // Primary state
   bba_pri_e    pri_ff, nxt_pri;
   logic        req_ff, nxt_req, park_ff, nxt_park, frame_ff, nxt_frame;
   logic        bk_cnt_ff, nxt_bk_cnt;
   // Secondary state
   bba_sec_e    sec_ff, nxt_sec;
   logic [2:0]  owner_ff, nxt_owner, hi_last_ff, nxt_hi_last;
   logic [2:0]  lo_last_ff, nxt_lo_last, hi_win, lo_win, win;
   logic [6:0]  gnt_ff, nxt_gnt, reqs, hi_req, lo_req;
   logic        hi_any, lo_any, ext_mode, tmr_exp, arb_to_evt, serr_fire;
   logic        gnt0_n_ff, nxt_gnt0_n, bgnt_ff, nxt_bgnt, g_oe_ff, nxt_g_oe;
   logic        pgnt;

   assign pgnt = !pri_grant_n;
   // Either control turns the internal arbiter off
   assign ext_mode = outside_arbiter_select
                     || arb_dis_ff[ARB_DIS_BIT];
   // Requests one to five are ignored in external mode
   assign reqs = {bridge_sec_req, ~downstream_requests_one_to_five_n,
                  ~downstream_request_zero_n};
   assign hi_req = reqs & tier_ff;
   assign lo_req = reqs & ~tier_ff;

   bba_rr_pick #(.N(NUM_MASTERS)) u_lo_pick (
      .req  (lo_req),
      .last (lo_last_ff),
      .win  (lo_win),
      .any  (lo_any)
   );

   bba_rr_pick #(.N(NUM_MASTERS + 1)) u_hi_pick (
      .req  ({lo_any, hi_req}),
      .last (hi_last_ff),
      .win  (hi_win),
      .any  (hi_any)
   );

   bba_grant_timer u_timer (
      .clock   (clock),
      .resetn  (resetn),
      .run     (sec_ff == SA_GRANT),
      .expired (tmr_exp)
   );

   assign win = (hi_win == 3'(LO_GROUP_SLOT)) ? lo_win : hi_win;

   // Secondary arbiter
   always_comb begin
      nxt_sec     = sec_ff;
      nxt_owner   = owner_ff;
      nxt_hi_last = hi_last_ff;
      nxt_lo_last = lo_last_ff;
      arb_to_evt  = 1'b0;
      case (sec_ff)
         SA_IDLE: begin
            if (!ext_mode && hi_any && sec_bus_idle) begin
               nxt_sec     = SA_GRANT;
               nxt_owner   = win;
               nxt_hi_last = hi_win;
               if (hi_win == 3'(LO_GROUP_SLOT)) begin
                  nxt_lo_last = lo_win;
               end
            end
         end
         SA_GRANT: begin
            if (ext_mode) begin
               nxt_sec = SA_IDLE;
            end else if (!sec_frame_n) begin
               nxt_sec = SA_OWN;
            end else if (tmr_exp) begin
               // Rotation already moved past the idle master
               arb_to_evt = 1'b1;
               nxt_sec    = SA_IDLE;
            end else if (!reqs[owner_ff]) begin
               nxt_sec = SA_IDLE;
            end
         end
         SA_OWN: begin
            if (sec_bus_idle) begin
               nxt_sec = SA_IDLE;
            end
         end
         default: nxt_sec = SA_IDLE;
      endcase
      nxt_gnt = (nxt_sec == SA_GRANT) ? onehot7(nxt_owner) : 7'h00;
      // External mode swaps the roles of pair zero
      nxt_gnt0_n = ext_mode ? !bridge_sec_req : !nxt_gnt[0];
      nxt_bgnt   = ext_mode ? !downstream_request_zero_n
                            : nxt_gnt[BRIDGE_IDX];
      nxt_g_oe   = !ext_mode;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sec_ff     <= SA_IDLE;
         owner_ff   <= 3'h0;
         hi_last_ff <= 3'h0;
         lo_last_ff <= 3'h0;
         gnt_ff     <= 7'h00;
         gnt0_n_ff  <= 1'b1;
         bgnt_ff    <= 1'b0;
         g_oe_ff    <= 1'b0;
      end else begin
         sec_ff     <= nxt_sec;
         owner_ff   <= nxt_owner;
         hi_last_ff <= nxt_hi_last;
         lo_last_ff <= nxt_lo_last;
         gnt_ff     <= nxt_gnt;
         gnt0_n_ff  <= nxt_gnt0_n;
         bgnt_ff    <= nxt_bgnt;
         g_oe_ff    <= nxt_g_oe;
      end
   end

   // Primary side
   always_comb begin
      nxt_pri    = pri_ff;
      nxt_bk_cnt = bk_cnt_ff;
      case (pri_ff)
         P_IDLE: begin
            if (fwd_pending) begin
               // Parked start skips the request; lost grant forces one
               nxt_pri = (park_ff && pgnt) ? P_START
                                           : P_REQ;
            end
         end
         P_REQ: begin
            if (pgnt && req_ff) begin
               nxt_pri = P_START;
            end
         end
         P_START: nxt_pri = P_BUSY;
         P_BUSY: begin
            if (pri_txn_retry) begin
               nxt_pri    = P_BACK;
               nxt_bk_cnt = 1'(BACKOFF_CYCLES - 1);
            end else if (pri_txn_done) begin
               // Queued work keeps the request up across the end
               nxt_pri = fwd_pending ? P_REQ : P_IDLE;
            end
         end
         P_BACK: begin
            if (bk_cnt_ff == 1'b0) begin
               nxt_pri = fwd_pending ? P_REQ : P_IDLE;
            end else begin
               nxt_bk_cnt = 1'b0;
            end
         end
         default: nxt_pri = P_IDLE;
      endcase
      nxt_req   = (nxt_pri == P_REQ) || (req_ff && fwd_pending
                  && (nxt_pri == P_START || nxt_pri == P_BUSY));
      nxt_frame = (nxt_pri == P_START);
      nxt_park  = (nxt_pri == P_IDLE || nxt_pri == P_BACK) && pgnt
                  && !nxt_req;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pri_ff    <= P_IDLE;
         bk_cnt_ff <= 1'b0;
         req_ff    <= 1'b0;
         frame_ff  <= 1'b0;
         park_ff   <= 1'b0;
      end else begin
         pri_ff    <= nxt_pri;
         bk_cnt_ff <= nxt_bk_cnt;
         req_ff    <= nxt_req;
         frame_ff  <= nxt_frame;
         park_ff   <= nxt_park;
      end
   end

   // Configuration registers and SERR
   assign serr_fire = arb_to_evt && serr_ctl_ff[SERR_ARB_TO_BIT]
                      && cmd_ff[CMD_SERR_EN_BIT];

   always_comb begin
      nxt_cmd      = cmd_ff;
      nxt_serr_ctl = serr_ctl_ff;
      nxt_arb_dis  = arb_dis_ff;
      nxt_tier     = tier_ff;
      nxt_serr_flag = serr_flag_ff;
      nxt_pstat    = pstat_ff;
      nxt_sstat    = sstat_ff;
      if (cfg_wr) begin
         case (cfg_addr)
            CMD_LO_OFS:   nxt_cmd[7:0]  = cfg_wdata;
            CMD_HI_OFS:   nxt_cmd[15:8] = cfg_wdata;
            SERR_CTL_OFS: nxt_serr_ctl  = cfg_wdata;
            ARB_DIS_OFS:  nxt_arb_dis   = cfg_wdata;
            TIER_OFS:     nxt_tier      = cfg_wdata[6:0];
            SERR_STS_OFS: nxt_serr_flag = serr_flag_ff
                          && !cfg_wdata[SERR_ARB_TO_BIT];
            PSTAT_HI_OFS: nxt_pstat = pstat_ff && !cfg_wdata[STAT_HI_BIT];
            SSTAT_HI_OFS: nxt_sstat = sstat_ff && !cfg_wdata[STAT_HI_BIT];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (serr_fire) begin
         nxt_serr_flag = 1'b1;
         nxt_pstat     = 1'b1;
      end
      if (!sec_syserr_n) begin
         nxt_sstat = 1'b1;
      end
      nxt_serr_oe = serr_fire;
      nxt_rdata   = 8'h00;
      if (cfg_rd) begin
         case (cfg_addr)
            CMD_LO_OFS:   nxt_rdata = cmd_ff[7:0];
            CMD_HI_OFS:   nxt_rdata = cmd_ff[15:8];
            SERR_CTL_OFS: nxt_rdata = serr_ctl_ff;
            SERR_STS_OFS: nxt_rdata = {7'h00, serr_flag_ff};
            ARB_DIS_OFS:  nxt_rdata = arb_dis_ff;
            TIER_OFS:     nxt_rdata = {1'b0, tier_ff};
            PSTAT_HI_OFS: nxt_rdata = 8'(pstat_ff) << STAT_HI_BIT;
            SSTAT_HI_OFS: nxt_rdata = 8'(sstat_ff) << STAT_HI_BIT;
            default:      nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_ff       <= CMD_RST;
         serr_ctl_ff  <= SERR_CTL_RST;
         arb_dis_ff   <= ARB_DIS_RST;
         tier_ff      <= TIER_RST;
         serr_flag_ff <= 1'b0;
         pstat_ff     <= 1'b0;
         sstat_ff     <= 1'b0;
         serr_oe_ff   <= 1'b0;
         rdata_ff     <= 8'h00;
         low_lvl_ff   <= 1'b0;
      end else begin
         cmd_ff       <= nxt_cmd;
         serr_ctl_ff  <= nxt_serr_ctl;
         arb_dis_ff   <= nxt_arb_dis;
         tier_ff      <= nxt_tier;
         serr_flag_ff <= nxt_serr_flag;
         pstat_ff     <= nxt_pstat;
         sstat_ff     <= nxt_sstat;
         serr_oe_ff   <= nxt_serr_oe;
         rdata_ff     <= nxt_rdata;
         low_lvl_ff   <= 1'b0;
      end
   end

   // Park level is all zeros, so even parity is zero too
   assign cfg_rdata                        = rdata_ff;
   assign pri_req_n                        = !req_ff;
   assign pri_start                        = frame_ff;
   assign upstream_cycle_frame_n           = !frame_ff;
   assign upstream_cycle_frame_oe          = frame_ff;
   assign upstream_addr_data_bus           = {32{low_lvl_ff}};
   assign upstream_addr_data_bus_oe        = park_ff;
   assign upstream_cmd_byte_enables        = {4{low_lvl_ff}};
   assign upstream_cmd_byte_enables_oe     = park_ff;
   assign upstream_parity                  = low_lvl_ff;
   assign upstream_parity_oe               = park_ff;
   assign pri_syserr_n                     = low_lvl_ff;
   assign pri_syserr_oe                    = serr_oe_ff;
   assign downstream_grant_zero_n          = gnt0_n_ff;
   assign downstream_grants_one_to_five_n  = ~gnt_ff[5:1];
   assign downstream_grants_one_to_five_oe = {5{g_oe_ff}};
   assign bridge_sec_gnt                   = bgnt_ff;

   property p_backoff;
      @(posedge clock) disable iff (!resetn)
      (pri_ff == P_BUSY && pri_txn_retry) |=> pri_req_n [*2];
   endproperty
   a_backoff: assert property (p_backoff)
      else $error("request not dropped two cycles after retry");

   property p_grant_start;
      @(posedge clock) disable iff (!resetn)
      (pri_ff == P_REQ && pgnt && !pri_req_n)
      |=> (!upstream_cycle_frame_n && upstream_cycle_frame_oe);
   endproperty
   a_grant_start: assert property (p_grant_start)
      else $error("no frame in cycle after grant");

   property p_park;
      @(posedge clock) disable iff (!resetn)
      (pri_ff == P_IDLE && pgnt && !fwd_pending && pri_req_n)
      |=> (upstream_addr_data_bus_oe && upstream_parity_oe
           && upstream_cmd_byte_enables_oe);
   endproperty
   a_park: assert property (p_park)
      else $error("bus not parked under idle grant");

   property p_frame_needs_grant;
      @(posedge clock) disable iff (!resetn)
      $rose(upstream_cycle_frame_oe) |-> $past(pgnt);
   endproperty
   a_frame_needs_grant: assert property (p_frame_needs_grant)
      else $error("frame started without grant");

   property p_req_held;
      @(posedge clock) disable iff (!resetn)
      (pri_ff == P_BUSY && fwd_pending && !pri_req_n
       && !pri_txn_retry) |=> !pri_req_n;
   endproperty
   a_req_held: assert property (p_req_held)
      else $error("request dropped while work queued");

   property p_ext_float;
      @(posedge clock) disable iff (!resetn)
      ext_mode |=> (downstream_grants_one_to_five_oe == 5'h00
                    && downstream_grant_zero_n == $past(!bridge_sec_req));
   endproperty
   a_ext_float: assert property (p_ext_float)
      else $error("external mode pins wrong");

   property p_one_grant;
      @(posedge clock) disable iff (!resetn)
      $onehot0(gnt_ff) and (ext_mode |=> gnt_ff == 7'h00);
   endproperty
   a_one_grant: assert property (p_one_grant)
      else $error("more than one grant or grant while disabled");

   property p_timeout;
      @(posedge clock) disable iff (!resetn)
      (sec_ff == SA_GRANT && sec_frame_n) [*8] ##1
      (sec_ff == SA_GRANT && sec_frame_n) [*8] ##1
      (sec_ff == SA_GRANT && sec_frame_n) |=> sec_ff != SA_GRANT;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("grant held past sixteen idle cycles");

   property p_serr;
      @(posedge clock) disable iff (!resetn)
      (arb_to_evt && serr_ctl_ff[0] && cmd_ff[8])
      |=> (pri_syserr_oe && serr_flag_ff && pstat_ff);
   endproperty
   a_serr: assert property (p_serr)
      else $error("timeout did not signal and flag SERR");

   property p_sstat;
      @(posedge clock) disable iff (!resetn)
      !sec_syserr_n |=> sstat_ff;
   endproperty
   a_sstat: assert property (p_sstat)
      else $error("secondary SERR not recorded");

   c_retry: cover property (@(posedge clock) disable iff (!resetn)
      pri_ff == P_BACK ##2 pri_ff == P_REQ);
   c_park_start: cover property (@(posedge clock) disable iff (!resetn)
      park_ff ##1 pri_ff == P_START);
   c_timeout: cover property (@(posedge clock) disable iff (!resetn)
      serr_fire);
   c_lo_tier: cover property (@(posedge clock) disable iff (!resetn)
      sec_ff == SA_IDLE && nxt_sec == SA_GRANT && hi_win == 3'h7);
endmodule : bba_arbiter

// File: testbench/bba_partner.sv
// Far side model: primary bus arbiter and the secondary bus masters.
// Assumes grants sampled on the bus clock; stall makes masters idle.
`timescale 1ns/100ps
module bba_partner #(
   parameter int GNT_DLY = 3
) (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       park,
   input  wire logic       stall,
   input  wire logic       ext,
   input  wire logic       pri_req_n,
   input  wire logic [6:0] sec_gnts,
   output logic            pri_grant_n,
   output logic            sec_frame_n,
   output logic            sec_bus_idle
);
   int unsigned wait_cnt;
   int unsigned busy_cnt;
   // Bus stays busy a few cycles after a frame, as a real transfer would
   assign sec_bus_idle = sec_frame_n && busy_cnt == 0;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wait_cnt    <= 0;
         busy_cnt    <= 0;
         pri_grant_n <= 1'b1;
         sec_frame_n <= 1'b1;
      end else begin
         wait_cnt <= pri_req_n ? 0 : wait_cnt + 1;
         // Slow grant on request, at once when parking
         pri_grant_n <= !(park || (!pri_req_n && wait_cnt >= GNT_DLY));
         // Stall is the idle master that never starts
         sec_frame_n <= !((|sec_gnts) && !ext && !stall && sec_bus_idle);
         if (!sec_frame_n) busy_cnt <= 3;
         else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      end
   end
endmodule : bba_partner

// File: testbench/tb_top.sv
// Self-checking bench for the bridge bus arbitration block.
// Assumes the partner model answers the primary and secondary buses.
`timescale 1ns/100ps
module tb_top
   import bba_pkg::*;
;
   logic        clock, resetn, cfg_wr, cfg_rd, fwd_pending, pri_txn_done;
   logic        pri_txn_retry, pri_grant_n, pri_req_n, pri_start, park;
   logic        upstream_cycle_frame_n, upstream_cycle_frame_oe, stall;
   logic        upstream_addr_data_bus_oe, upstream_parity, upstream_parity_oe;
   logic        upstream_cmd_byte_enables_oe, pri_syserr_n, pri_syserr_oe;
   logic        outside_arbiter_select, downstream_request_zero_n;
   logic        downstream_grant_zero_n, bridge_sec_req, bridge_sec_gnt;
   logic        sec_frame_n, sec_bus_idle, sec_syserr_n, s;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, rd;
   logic [31:0] upstream_addr_data_bus, seed;
   logic [3:0]  upstream_cmd_byte_enables;
   logic [4:0]  downstream_requests_one_to_five_n;
   logic [4:0]  downstream_grants_one_to_five_n, downstream_grants_one_to_five_oe;
   logic [6:0]  gvec, got;
   int          errors, total_checks, i, n, m;
   assign gvec = {bridge_sec_gnt, downstream_grants_one_to_five_oe
                  & ~downstream_grants_one_to_five_n, ~downstream_grant_zero_n};

   bba_arbiter u_bba_arbiter (.clock, .resetn, .cfg_addr, .cfg_wr, .cfg_rd,
      .cfg_wdata, .cfg_rdata, .fwd_pending, .pri_txn_done, .pri_txn_retry,
      .pri_grant_n, .pri_req_n, .pri_start, .upstream_cycle_frame_n,
      .upstream_cycle_frame_oe, .upstream_addr_data_bus,
      .upstream_addr_data_bus_oe, .upstream_cmd_byte_enables,
      .upstream_cmd_byte_enables_oe, .upstream_parity, .upstream_parity_oe,
      .pri_syserr_n, .pri_syserr_oe, .outside_arbiter_select,
      .downstream_request_zero_n, .downstream_requests_one_to_five_n,
      .downstream_grant_zero_n, .downstream_grants_one_to_five_n,
      .downstream_grants_one_to_five_oe, .bridge_sec_req, .bridge_sec_gnt,
      .sec_frame_n, .sec_bus_idle, .sec_syserr_n);
   bba_partner u_bba_partner (.clock, .resetn, .park, .stall,
      .ext(outside_arbiter_select), .pri_req_n, .sec_gnts(gvec), .pri_grant_n,
      .sec_frame_n, .sec_bus_idle);

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : tick
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (e !== g) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) begin cfg_addr <= a; cfg_wdata <= d; cfg_wr <= 1'b1; end
      @(posedge clock) cfg_wr <= 1'b0;
   endtask : cfg_write
   task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock) begin cfg_addr <= a; cfg_rd <= 1'b1; end
      @(posedge clock) cfg_rd <= 1'b0;
      #1 d = cfg_rdata;
   endtask : cfg_read
   // Master 1 requests (bridge too if wb); counts its grant cycles to SERR
   task automatic arb_to(input logic wb);
      @(posedge clock) begin
         downstream_requests_one_to_five_n <= 5'h1e;
         bridge_sec_req <= wb;
      end
      n = 0; s = 0; got = 0;
      repeat (60) begin
         tick(1);
         got |= gvec;
         if (!s && gvec[1]) n++;
         if (pri_syserr_oe === 1'b1 && pri_syserr_n === 1'b0) s = 1;
      end
      @(posedge clock) begin
         downstream_requests_one_to_five_n <= 5'h1f;
         bridge_sec_req <= 1'b0;
      end
      tick(4);
   endtask : arb_to
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Run takes about five hundred and fifty cycles
   initial begin
      #50000;
      errors++;
      end_sim();
   end
   initial begin
      {cfg_wr, cfg_rd, fwd_pending, pri_txn_done, pri_txn_retry} = 5'h00;
      {park, stall, outside_arbiter_select, bridge_sec_req} = 4'h0;
      {downstream_request_zero_n, sec_syserr_n} = 2'h3;
      // Unused requests held high, as the board pulls them
      downstream_requests_one_to_five_n = 5'h1f;
      cfg_addr = 8'h00; cfg_wdata = 8'h00; seed = 32'h34b1; resetn = 1'b0;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      tick(2);
      cfg_read(ARB_DIS_OFS, rd); chk("arb_dis_rst", 8'h00, rd);
      cfg_read(8'h80, rd); chk("unmapped", 8'h00, rd);
      @(posedge clock) fwd_pending <= 1'b1;
      for (i = 0; i < 6 && pri_req_n !== 1'b0; i++) tick(1);
      chk("pri_req", 0, pri_req_n);
      for (i = 0; i < 9 && pri_grant_n !== 1'b0; i++) tick(1);
      tick(1);
      chk("start", 3'b101, {pri_start, upstream_cycle_frame_n,
          upstream_cycle_frame_oe});
      tick(2); chk("req_held", 0, pri_req_n);
      @(posedge clock) pri_txn_retry <= 1'b1;
      @(posedge clock) pri_txn_retry <= 1'b0;
      #1 n = 0;
      for (i = 0; i < 8 && pri_req_n !== 1'b0; i++) begin n++; tick(1); end
      chk("backoff", BACKOFF_CYCLES, n);
      for (i = 0; i < 12 && pri_start !== 1'b1; i++) tick(1);
      @(posedge clock) begin pri_txn_done <= 1'b1; fwd_pending <= 1'b0; end
      @(posedge clock) begin pri_txn_done <= 1'b0; park <= 1'b1; end
      for (i = 0; i < 8 && upstream_addr_data_bus_oe !== 1'b1; i++) tick(1);
      chk("park_oe", 3'b111, {upstream_addr_data_bus_oe,
          upstream_cmd_byte_enables_oe, upstream_parity_oe});
      chk("park_lvl", 0, upstream_addr_data_bus
          | {upstream_cmd_byte_enables, upstream_parity});
      @(posedge clock) fwd_pending <= 1'b1;
      for (i = 0; i < 4 && pri_start !== 1'b1; i++) tick(1);
      chk("park_start", 2'b11, {pri_start, pri_req_n});
      @(posedge clock) begin pri_txn_done <= 1'b1; fwd_pending <= 1'b0; end
      @(posedge clock) begin pri_txn_done <= 1'b0; park <= 1'b0; end
      tick(4);
      @(posedge clock) fwd_pending <= 1'b1;
      s = 0;
      for (i = 0; i < 20 && pri_start !== 1'b1; i++) begin
         if (pri_req_n === 1'b0) s = 1;
         tick(1);
      end
      chk("rearbitrate", 2'b11, {s, pri_start});
      @(posedge clock) begin pri_txn_done <= 1'b1; fwd_pending <= 1'b0; end
      @(posedge clock) pri_txn_done <= 1'b0;
      cfg_write(TIER_OFS, {1'b0, seed[6:0]});
      cfg_read(TIER_OFS, rd); chk("tier", {1'b0, seed[6:0]}, rd);
      got = 0;
      repeat (300) begin
         @(posedge clock) begin
            seed = lfsr_next(seed);
            downstream_requests_one_to_five_n <= seed[4:0];
            downstream_request_zero_n <= seed[5];
            bridge_sec_req <= seed[6];
         end
         #1 got |= gvec;
         chk("one_grant", 1, $countones(gvec) <= 1);
      end
      chk("all_served", 7'h7f, got);
      @(posedge clock) begin downstream_request_zero_n <= 1'b1; stall <= 1'b1; end
      arb_to(1'b1);
      chk("no_serr", 0, s);
      chk("others_go_on", 2'b11, {got[6], got[1]});
      cfg_read(SERR_STS_OFS, rd); chk("flag_off", 8'h00, rd);
      cfg_write(CMD_HI_OFS, 8'h01);
      cfg_write(SERR_CTL_OFS, 8'h01);
      cfg_read(SERR_CTL_OFS, rd); chk("serr_ctl", 8'h01, rd);
      arb_to(1'b0);
      chk("serr", 1, s);
      chk("to_len", 1, n >= ARB_TIMEOUT_CYCLES && n <= 18);
      cfg_read(PSTAT_HI_OFS, rd); chk("pstat", 8'h40, rd);
      cfg_write(PSTAT_HI_OFS, 8'h40);
      cfg_read(PSTAT_HI_OFS, rd); chk("pstat_clr", 8'h00, rd);
      cfg_write(SERR_STS_OFS, 8'h00);
      cfg_read(SERR_STS_OFS, rd); chk("flag_keep", 8'h01, rd);
      cfg_write(SERR_STS_OFS, 8'h01);
      cfg_read(SERR_STS_OFS, rd); chk("flag_clear", 8'h00, rd);
      @(posedge clock) sec_syserr_n <= 1'b0;
      @(posedge clock) begin sec_syserr_n <= 1'b1; stall <= 1'b0; end
      cfg_read(SSTAT_HI_OFS, rd); chk("sstat", 8'h40, rd);
      cfg_write(SSTAT_HI_OFS, 8'h40);
      cfg_read(SSTAT_HI_OFS, rd); chk("sstat_clr", 8'h00, rd);
      for (m = 0; m < 2; m++) begin
         if (m == 0) @(posedge clock) outside_arbiter_select <= 1'b1;
         else cfg_write(ARB_DIS_OFS, 8'h40);
         @(posedge clock) bridge_sec_req <= 1'b1;
         tick(3);
         chk("ext_oe", 0, downstream_grants_one_to_five_oe);
         chk("ext_req", 2'b00, {downstream_grant_zero_n, bridge_sec_gnt});
         @(posedge clock) downstream_request_zero_n <= 1'b0;
         tick(3); chk("ext_gnt", 1, bridge_sec_gnt);
         @(posedge clock) begin
            downstream_request_zero_n <= 1'b1;
            bridge_sec_req <= 1'b0;
            outside_arbiter_select <= 1'b0;
         end
         tick(2);
      end
      end_sim();
   end
endmodule : tb_top
